// file: src/mode_pkg.sv
// Shared constants, types and decode functions for the base mode register.
// Assumes one 20 MHz command clock shared by both ends and the link interface.
`default_nettype none

package mode_pkg;

  localparam int MODE_W = 18;
  localparam int DATA_W = 8;
  localparam int COL_W = 10;
  localparam int BEATS = 8;

  // Field positions
  localparam int BL_LO = 0;
  localparam int RL_EXT_BIT = 2;
  localparam int BT_BIT = 3;
  localparam int RL_LO = 4;
  localparam int DLL_RST_BIT = 8;
  localparam int WR_LO = 9;
  localparam int PPD_BIT = 12;
  localparam int BSEL_BIT = 12;
  localparam logic [MODE_W-1:0] RSV_MASK = 18'h26080;
  localparam logic [MODE_W-1:0] MODE_RESET = 18'h00000;

  // Burst length field codes
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_CHOP4 = 2'h2;

  // Timing in cycles of the 50 ns clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int WR_TIME_NS = 15;
  localparam int WR_MIN_CYCLES = (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] DLL_LOCK_CYCLES = 10'h200;
  localparam logic [4:0] MOD_CYCLES = 5'h0c;
  localparam logic [4:0] XP_CYCLES = 5'h03;
  localparam logic [4:0] XPDLL_CYCLES = 5'h0a;
  localparam logic [4:0] SLOT_CYCLES = 5'h08;
  localparam logic [4:0] CHOP_TAIL = 5'h04;

  typedef enum logic [1:0] {CMD_NOP = 2'h0, CMD_MRS = 2'h1, CMD_RD = 2'h2, CMD_WR = 2'h3} cmd_e;

  // Read latency: bit 2 extends the three-bit field past eleven
  function automatic logic [4:0] rl_cycles(input logic [MODE_W-1:0] m);
    logic [4:0] f;
    f = {2'h0, m[RL_LO+:3]};
    rl_cycles = m[RL_EXT_BIT] ? (5'h0c + f) : (5'h04 + f);
  endfunction : rl_cycles

  // Write recovery code to cycles; code zero is not allowed and reads as the longest
  function automatic logic [4:0] wr_cycles(input logic [2:0] c);
    unique case (c)
      3'h1: wr_cycles = 5'h05;
      3'h2: wr_cycles = 5'h06;
      3'h3: wr_cycles = 5'h07;
      3'h4: wr_cycles = 5'h08;
      3'h5: wr_cycles = 5'h0a;
      3'h6: wr_cycles = 5'h0c;
      default: wr_cycles = 5'h0e;
    endcase
  endfunction : wr_cycles

  // Smallest allowed code covering the needed cycle count
  function automatic logic [2:0] wr_code(input int cyc);
    if (cyc <= 5) wr_code = 3'h1;
    else if (cyc <= 8) wr_code = 3'(cyc - 4);
    else if (cyc <= 10) wr_code = 3'h5;
    else if (cyc <= 12) wr_code = 3'h6;
    else wr_code = 3'h7;
  endfunction : wr_code

  // Column of one beat inside its aligned block of eight
  function automatic logic [2:0] beat_col(input logic [2:0] st, input logic [2:0] b,
                                          input logic inter, input logic chop, input logic wr);
    if (wr)
      beat_col = chop ? {st[2], b[1:0]} : b;
    else if (inter)
      beat_col = st ^ b;
    else
      beat_col = {st[2] ^ b[2], 2'(st[1:0] + b[1:0])};
  endfunction : beat_col

  localparam logic [2:0] WR_CODE = wr_code(WR_MIN_CYCLES);

endpackage : mode_pkg

`default_nettype wire

// file: src/mode_link.sv
// Command and data link between the controller end and the memory end.
// Assumes both ends run on the same clock; resolves the shared data wire here.
`default_nettype none

interface mode_link;
  import mode_pkg::*;

  logic cke;
  cmd_e cmd;
  logic [MODE_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wd_oe_n;
  logic [DATA_W-1:0] rdata;
  logic rd_oe_n;
  wire [DATA_W-1:0] dq;

  // Shared data wire: whichever end has its enable low drives it, the memory end if both are low; released, it reads low
  assign dq = !rd_oe_n ? rdata : (!wd_oe_n ? wdata : {DATA_W{1'b0}});

  modport ctrl (output cke, output cmd, output addr, output wdata, output wd_oe_n,
                input rd_oe_n, input dq);
  modport mem (input cke, input cmd, input addr, input wd_oe_n,
               output rdata, output rd_oe_n, input dq);
endinterface : mode_link

`default_nettype wire

// file: src/mode_mem_end.sv
// Memory end: holds the base mode register and runs bursts in its order.
// Assumes the controller keeps its own timing duties; eight columns of storage.
`default_nettype none

module mode_mem_end (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link
  mode_link.mem lnk,
  // Status
  output logic [mode_pkg::MODE_W-1:0] mode_out,
  output logic dll_locked,
  output logic dll_running,
  output logic [4:0] read_latency,
  output logic [4:0] write_recovery,
  // Beat monitor
  output logic beat_valid,
  output logic beat_write,
  output logic [mode_pkg::COL_W-1:0] beat_col_out,
  output logic [mode_pkg::DATA_W-1:0] beat_data
);
  import mode_pkg::*;

  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_WAIT = 3'b010, ST_BEAT = 3'b100} st_e;

  st_e st_r, st_nxt;
  logic [MODE_W-1:0] mode_r;
  logic [9:0] lock_cnt_r;
  logic locked_r;
  logic pd_r;
  logic [4:0] lat_r;
  logic [2:0] beat_r;
  logic [2:0] start_r;
  logic [COL_W-4:0] blk_r;
  logic wr_r, chop_r, inter_r;
  logic [DATA_W-1:0] mem_r [BEATS];
  logic [DATA_W-1:0] rdata_r;
  logic rd_oe_n_r;
  logic bv_r, bw_r;
  logic [COL_W-1:0] bc_r;
  logic [DATA_W-1:0] bd_r;

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  wire cmd_on = lnk.cke && (st_r == ST_IDLE);
  wire take_mrs = cmd_on && (lnk.cmd == CMD_MRS);
  wire take_rw = cmd_on && ((lnk.cmd == CMD_RD) || (lnk.cmd == CMD_WR));
  wire [1:0] bl_f = mode_r[BL_LO+:2];
  // Burst-select bit counts only under the per-command setting
  wire cmd_chop = (bl_f == BL_CHOP4) || ((bl_f == BL_OTF) && !lnk.addr[BSEL_BIT]);
  wire [4:0] rl = rl_cycles(mode_r);
  wire dll_rst_req = take_mrs && lnk.addr[DLL_RST_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Slot sequencing: all eight slots run for both lengths
  wire first_slot = (st_r == ST_WAIT) && (lat_r == 5'h00);
  wire more_slot = (st_r == ST_BEAT) && (beat_r != 3'h7);
  wire slot_nxt = first_slot || more_slot;
  wire [2:0] nb = first_slot ? 3'h0 : 3'(beat_r + 3'h1);
  wire nb_live = !(chop_r && nb[2]);
  wire cur_live = !(chop_r && beat_r[2]);
  wire [2:0] col_nxt = beat_col(start_r, nb, inter_r, chop_r, wr_r);
  wire [2:0] col_cur = beat_col(start_r, beat_r, inter_r, chop_r, wr_r);
  wire wr_here = (st_r == ST_BEAT) && wr_r && cur_live;

  // Next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: if (take_rw) st_nxt = ST_WAIT;
      ST_WAIT: if (lat_r == 5'h00) st_nxt = ST_BEAT;
      ST_BEAT: if (beat_r == 3'h7) st_nxt = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode register: reserved bits are dropped, reset bit never stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= MODE_RESET;
    end else if (take_mrs) begin
      mode_r <= lnk.addr & ~RSV_MASK & ~(MODE_W'(1) << DLL_RST_BIT);
    end
  end

  // DLL lock wait; counts only while clock enable is high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_cnt_r <= 10'h000;
      locked_r <= 1'b0;
    end else if (dll_rst_req) begin
      lock_cnt_r <= DLL_LOCK_CYCLES;
      locked_r <= 1'b0;
    end else if (lnk.cke && (lock_cnt_r != 10'h000)) begin
      lock_cnt_r <= lock_cnt_r - 10'h001;
      locked_r <= (lock_cnt_r == 10'h001);
    end
  end

  // Precharge power-down follows clock enable while idle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pd_r <= 1'b0;
    end else begin
      pd_r <= !lnk.cke && (st_r == ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst capture; latency counted so beat 0 appears at edge n plus latency
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      lat_r <= 5'h00;
      beat_r <= 3'h0;
      start_r <= 3'h0;
      blk_r <= '0;
      wr_r <= 1'b0;
      chop_r <= 1'b0;
      inter_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (take_rw) begin
        lat_r <= rl - 5'h01;
        start_r <= lnk.addr[2:0];
        blk_r <= lnk.addr[COL_W-1:3];
        wr_r <= (lnk.cmd == CMD_WR);
        chop_r <= cmd_chop;
        inter_r <= mode_r[BT_BIT];
      end else if ((st_r == ST_WAIT) && (lat_r != 5'h00)) begin
        lat_r <= lat_r - 5'h01;
      end
      if (slot_nxt) begin
        beat_r <= nb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Column storage, one flip-flop word per column of the block
  for (genvar i = 0; i < BEATS; i++) begin : g_col
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        mem_r[i] <= '0;
      end else if (wr_here && (col_cur == 3'(i))) begin
        mem_r[i] <= lnk.dq;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read drive: chopped tail slots leave the data wire released
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= '0;
      rd_oe_n_r <= 1'b1;
    end else begin
      rd_oe_n_r <= !(slot_nxt && !wr_r && nb_live);
      rdata_r <= mem_r[col_nxt];
    end
  end

  // Beat monitor for the user side; write beats shown as stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bv_r <= 1'b0;
      bw_r <= 1'b0;
      bc_r <= '0;
      bd_r <= '0;
    end else begin
      bv_r <= (slot_nxt && !wr_r && nb_live) || wr_here;
      bw_r <= wr_here;
      bc_r <= wr_here ? {blk_r, col_cur} : {blk_r, col_nxt};
      bd_r <= wr_here ? lnk.dq : mem_r[col_nxt];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status outputs, all registered
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_latency <= 5'h00;
      write_recovery <= 5'h00;
      dll_running <= 1'b1;
    end else begin
      read_latency <= rl;
      write_recovery <= wr_cycles(mode_r[WR_LO+:3]);
      // Bit 12 low trades a slow exit for lower standby current
      dll_running <= !(pd_r && !mode_r[PPD_BIT]);
    end
  end

  assign mode_out = mode_r;
  assign dll_locked = locked_r;
  assign beat_valid = bv_r;
  assign beat_write = bw_r;
  assign beat_col_out = bc_r;
  assign beat_data = bd_r;
  assign lnk.rdata = rdata_r;
  assign lnk.rd_oe_n = rd_oe_n_r;

endmodule : mode_mem_end

`default_nettype wire

// file: src/mode_ctrl_end.sv
// Controller end: loads the mode register and runs bursts to its settings.
// Assumes one request port and the memory end on the same clock.
`default_nettype none

module mode_ctrl_end (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link
  mode_link.ctrl lnk,
  // Requests
  input wire logic req_valid,
  input wire mode_pkg::cmd_e req_op,
  input wire logic [mode_pkg::MODE_W-1:0] req_addr,
  output logic req_ready,
  // Write data
  input wire logic [mode_pkg::DATA_W-1:0] wr_data,
  output logic wr_take,
  // Read data
  output logic rd_valid,
  output logic [mode_pkg::DATA_W-1:0] rd_data,
  // Power-down and status
  input wire logic pd_req,
  output logic dll_ready
);
  import mode_pkg::*;

  typedef enum logic [3:0] {H_IDLE = 4'b0001, H_BURST = 4'b0010, H_GAP = 4'b0100, H_PD = 4'b1000} hst_e;

  hst_e st_r;
  logic [MODE_W-1:0] mode_r;
  logic [4:0] cnt_r, gap_r;
  logic [9:0] lock_r;
  logic wr_r, chop_r, cke_r, ready_r, wdoe_n_r, take_r, rv_r;
  cmd_e cmd_r;
  logic [MODE_W-1:0] addr_r;
  logic [DATA_W-1:0] wd_r, rd_r;

  ////////////////////////////////////////////////////////////////////////
  // Request decode; reads wait for the DLL lock count
  wire lock_busy = (lock_r != 10'h000);
  wire take = ready_r && req_valid && !((req_op == CMD_RD) && lock_busy) && (req_op != CMD_NOP);
  wire is_mrs = take && (req_op == CMD_MRS);
  wire is_rw = take && !is_mrs;
  // Reserved bits forced low, recovery code from the rounded-up time
  wire [MODE_W-1:0] mrs_val = (req_addr & ~RSV_MASK & ~(MODE_W'(3'h7) << WR_LO))
                              | (MODE_W'(WR_CODE) << WR_LO);
  wire [1:0] bl_f = mode_r[BL_LO+:2];
  wire req_chop = (bl_f == BL_CHOP4) || ((bl_f == BL_OTF) && !req_addr[BSEL_BIT]);
  wire [4:0] cnt_nxt = (st_r == H_BURST) ? 5'(cnt_r - 5'h01) : 5'(rl_cycles(mode_r) + SLOT_CYCLES);
  // Slot 0 lands on command edge plus latency, the same edge the memory end drives read beat 0 from
  wire slot = (st_r == H_BURST) && (cnt_nxt < SLOT_CYCLES);
  wire live = !(chop_r && (cnt_nxt < CHOP_TAIL));
  wire [4:0] exit_gap = mode_r[PPD_BIT] ? XP_CYCLES : XPDLL_CYCLES;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= H_IDLE;
      mode_r <= MODE_RESET;
      cnt_r <= 5'h00;
      gap_r <= 5'h00;
      wr_r <= 1'b0;
      chop_r <= 1'b0;
      cke_r <= 1'b1;
      cmd_r <= CMD_NOP;
      addr_r <= '0;
    end else begin
      cmd_r <= CMD_NOP;
      unique case (st_r)
        H_IDLE: begin
          if (is_mrs) begin
            cmd_r <= CMD_MRS;
            addr_r <= mrs_val;
            mode_r <= mrs_val & ~(MODE_W'(1) << DLL_RST_BIT);
            gap_r <= MOD_CYCLES;
            st_r <= H_GAP;
          end else if (is_rw) begin
            cmd_r <= req_op;
            addr_r <= req_addr;
            wr_r <= (req_op == CMD_WR);
            chop_r <= req_chop;
            cnt_r <= cnt_nxt;
            st_r <= H_BURST;
          end else if (pd_req) begin
            cke_r <= 1'b0;
            st_r <= H_PD;
          end
        end
        H_BURST: begin
          cnt_r <= cnt_nxt;
          if (cnt_nxt == 5'h00) begin
            gap_r <= wr_r ? wr_cycles(mode_r[WR_LO+:3]) : 5'h00;
            st_r <= H_GAP;
          end
        end
        H_GAP: begin
          if (gap_r <= 5'h01) st_r <= H_IDLE;
          gap_r <= (gap_r == 5'h00) ? 5'h00 : 5'(gap_r - 5'h01);
        end
        H_PD: begin
          if (!pd_req) begin
            cke_r <= 1'b1;
            gap_r <= exit_gap;
            st_r <= H_GAP;
          end
        end
      endcase
    end
  end

  // Lock wait after a DLL reset load, counted with clock enable high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_r <= 10'h000;
    end else if (is_mrs && req_addr[DLL_RST_BIT]) begin
      lock_r <= DLL_LOCK_CYCLES;
    end else if (cke_r && lock_busy) begin
      lock_r <= lock_r - 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data slots and request handshake
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_r <= 1'b0;
      wdoe_n_r <= 1'b1;
      take_r <= 1'b0;
      wd_r <= '0;
      rv_r <= 1'b0;
      rd_r <= '0;
    end else begin
      ready_r <= (st_r == H_IDLE) && !take && !pd_req;
      take_r <= slot && wr_r && live;
      wdoe_n_r <= !(slot && wr_r && live);
      wd_r <= wr_data;
      rv_r <= !lnk.rd_oe_n;
      rd_r <= lnk.dq;
    end
  end

  assign lnk.cke = cke_r;
  assign lnk.cmd = cmd_r;
  assign lnk.addr = addr_r;
  assign lnk.wdata = wd_r;
  assign lnk.wd_oe_n = wdoe_n_r;
  assign req_ready = ready_r;
  assign wr_take = take_r;
  assign rd_valid = rv_r;
  assign rd_data = rd_r;
  assign dll_ready = !lock_busy;

endmodule : mode_ctrl_end

`default_nettype wire

// file: verification/mode_checker.sv
// Link-side checker for the controller and memory ends of the mode link.
// Assumes one clock and that only one burst is in flight at a time.
`default_nettype none

module mode_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link
  input wire logic cke,
  input wire mode_pkg::cmd_e cmd,
  input wire logic [mode_pkg::MODE_W-1:0] addr,
  input wire logic wd_oe_n,
  input wire logic rd_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import mode_pkg::*;

  logic [MODE_W-1:0] mode_r;
  logic [9:0] dll_cnt_r;
  logic [4:0] lat_cnt_r;
  logic chop_r;
  logic wr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the stored mode; latency decoded here, not borrowed from the package
  wire [4:0] lat_cfg = mode_r[2] ? 5'h0c + {2'h0, mode_r[6:4]} : 5'h04 + {2'h0, mode_r[6:4]};
  wire chop_now = (mode_r[1:0] == BL_CHOP4) || (mode_r[1:0] == BL_OTF && !addr[BSEL_BIT]);
  wire is_rw = (cmd == CMD_RD) || (cmd == CMD_WR);

  // Cycles since a lock restart saturate, so a long idle never wraps into a false wait
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= MODE_RESET;
      dll_cnt_r <= 10'h3ff;
      lat_cnt_r <= 5'h00;
      chop_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      if (cmd == CMD_MRS) mode_r <= addr;
      if (cmd == CMD_MRS && addr[DLL_RST_BIT]) dll_cnt_r <= 10'h000;
      else if (dll_cnt_r != 10'h3ff) dll_cnt_r <= dll_cnt_r + 10'h001;
      if (is_rw) begin
        lat_cnt_r <= lat_cfg;
        chop_r <= chop_now;
        wr_r <= (cmd == CMD_WR);
      end else if (lat_cnt_r != 5'h00) lat_cnt_r <= lat_cnt_r - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_idle8; (cmd == CMD_NOP)[*8]; endsequence
  sequence s_out4; (!rd_oe_n)[*4]; endsequence
  sequence s_off4; rd_oe_n[*4]; endsequence

  a_reserved_zero: assert property (cmd == CMD_MRS |-> (addr & RSV_MASK) == '0)
    else $error("reserved mode bits loaded nonzero");
  a_wr_code_up: assert property (cmd == CMD_MRS |-> addr[11:9] == 3'h1)
    else $error("write recovery code not the rounded-up value");
  a_mode_quiet: assert property (cmd == CMD_MRS |=> s_idle8)
    else $error("command issued inside mode update delay");
  a_dll_wait: assert property (cmd == CMD_RD |-> dll_cnt_r >= 10'h1ff)
    else $error("read issued before lock wait elapsed");
  a_read_latency: assert property (lat_cnt_r == 5'h01 && !wr_r |=> $fell(rd_oe_n))
    else $error("first read beat not at command edge plus latency");
  a_write_latency: assert property (lat_cnt_r == 5'h01 && wr_r |=> $fell(wd_oe_n))
    else $error("write data window misplaced");
  a_chop_tristate: assert property ($fell(rd_oe_n) && chop_r |-> s_out4 ##1 s_off4)
    else $error("chopped read not four beats then four released slots");
  a_eight_beats: assert property ($fell(rd_oe_n) && !chop_r |-> s_out4 ##1 s_out4 ##1 rd_oe_n)
    else $error("eight-beat read not eight driven slots");
  a_slow_exit: assert property ($rose(cke) && !mode_r[PPD_BIT] |-> s_idle8)
    else $error("command too soon after slow power-down exit");
  a_fast_exit: assert property ($rose(cke) |-> (cmd == CMD_NOP)[*3])
    else $error("command too soon after power-down exit");
  a_mrs_when_idle: assert property (cmd == CMD_MRS |-> rd_oe_n && wd_oe_n && (lat_cnt_r == 5'h00))
    else $error("mode register loaded while a burst is in progress");

endmodule : mode_checker

`default_nettype wire

// file: verification/sdram_base_mode_register_decode_bench.sv
// Bench joining the controller and memory ends across the mode link.
// Assumes the link resolves the shared data wire; memory holds eight columns.
`default_nettype none

module sdram_base_mode_register_decode_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mode_pkg::*;

  logic clk, sys_rst, req_valid, req_ready, wr_take, rd_valid, pd_req, dll_ready;
  logic dll_locked, dll_running, beat_valid, beat_write;
  cmd_e req_op;
  logic [17:0] req_addr, mode_out;
  logic [7:0] wr_data, last_wd, rd_data, beat_data;
  logic [4:0] read_latency, write_recovery;
  logic [9:0] beat_col_out;
  logic [10:0] cq[$];
  logic [7:0] rq[$], wq[$], bq[$], mem_exp[8];
  int n_errors = 0, total_checks = 0, cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Design, link and checker
  mode_link u_mode_link ();
  mode_mem_end u_mode_mem_end (.clk(clk), .sys_rst(sys_rst), .lnk(u_mode_link), .mode_out(mode_out),
    .dll_locked(dll_locked), .dll_running(dll_running), .read_latency(read_latency),
    .write_recovery(write_recovery), .beat_valid(beat_valid), .beat_write(beat_write),
    .beat_col_out(beat_col_out), .beat_data(beat_data));
  mode_ctrl_end u_mode_ctrl_end (.clk(clk), .sys_rst(sys_rst), .lnk(u_mode_link), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_ready(req_ready), .wr_data(wr_data), .wr_take(wr_take),
    .rd_valid(rd_valid), .rd_data(rd_data), .pd_req(pd_req), .dll_ready(dll_ready));
  mode_checker u_mode_checker (.clk(clk), .sys_rst(sys_rst), .cke(u_mode_link.cke), .cmd(u_mode_link.cmd),
    .addr(u_mode_link.addr), .wd_oe_n(u_mode_link.wd_oe_n), .rd_oe_n(u_mode_link.rd_oe_n));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Write data steps every cycle; last_wd is what the controller took at the previous edge
  always @(posedge clk) begin
    last_wd <= wr_data;
    wr_data <= wr_data + 8'h01;
    if (wr_take === 1'b1) wq.push_back(last_wd);
    if (beat_valid === 1'b1) begin
      cq.push_back({beat_write, beat_col_out});
      bq.push_back(beat_data);
    end
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results;
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // Request held until the edge where the controller takes it
  task automatic req(input cmd_e op, input logic [17:0] a);
    int k;
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    for (k = 0; k < 2000; k++) begin
      @(posedge clk);
      if (req_ready === 1'b1 && (op != CMD_RD || dll_ready === 1'b1)) break;
    end
    req_valid <= 1'b0;
    check("req_taken", 18'(k < 2000), 18'h1);
  endtask : req

  task automatic mrs(input logic [17:0] a, input logic [17:0] exp, input logic [4:0] rl);
    req(CMD_MRS, a);
    repeat (4) @(posedge clk);
    check("mode_out", mode_out, exp);
    check("read_latency", 18'(read_latency), 18'(rl));
    check("write_recovery", 18'(write_recovery), 18'h5);
  endtask : mrs

  // Expected column of beat b, worked out independently of the design
  function automatic logic [2:0] ord(input logic [2:0] s, input logic [2:0] b, input logic inter,
                                     input logic chop, input logic wr);
    if (wr) return chop ? {s[2], b[1:0]} : b;
    if (inter) return s ^ b;
    return {s[2] ^ b[2], 2'(s[1:0] + b[1:0])};
  endfunction : ord

  // One burst; writes update the expected memory, reads compare against it
  task automatic burst(input cmd_e op, input logic [2:0] st, input logic bsel, input logic inter,
                       input logic chop);
    int n;
    int k;
    logic [2:0] c;
    n = chop ? 4 : 8;
    cq.delete();
    rq.delete();
    wq.delete();
    bq.delete();
    req(op, {5'h00, bsel, 9'h000, st});
    for (k = 0; k < 200 && !(cq.size() >= n && (op == CMD_WR || rq.size() >= n)); k++) @(posedge clk);
    repeat (6) @(posedge clk);
    check("beat_count", 18'(cq.size()), 18'(n));
    for (int b = 0; b < n; b++) begin
      c = ord(st, 3'(b), inter, chop, op == CMD_WR);
      check("beat_col", 18'(cq[b]), 18'({op == CMD_WR, 7'h00, c}));
      if (op == CMD_WR) mem_exp[c] = wq[b];
      else check("rd_data", 18'(rq[b]), 18'(mem_exp[c]));
      check("beat_data", 18'(bq[b]), 18'(mem_exp[c]));
    end
  endtask : burst

  task automatic pd(input logic run);
    pd_req <= 1'b1;
    repeat (10) @(posedge clk);
    check("dll_running", 18'(dll_running), 18'(run));
    pd_req <= 1'b0;
  endtask : pd

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_op = CMD_NOP;
    req_addr = 18'h00000;
    pd_req = 1'b0;
    wr_data = 8'h00;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check("mode_reset", mode_out, 18'h00000);
    mrs(18'h27fa9, 18'h01229, 5'h06);
    check("dll_ready", 18'(dll_ready), 18'h0);
    check("dll_locked", 18'(dll_locked), 18'h0);
    burst(CMD_WR, 3'h5, 1'b1, 1'b1, 1'b0);
    burst(CMD_WR, 3'h6, 1'b0, 1'b1, 1'b1);
    burst(CMD_RD, 3'h5, 1'b1, 1'b1, 1'b0);
    check("dll_locked", 18'(dll_locked), 18'h1);
    burst(CMD_RD, 3'h6, 1'b0, 1'b1, 1'b1);
    @(posedge clk);
    pd(1'b1);
    mrs(18'h00016, 18'h00216, 5'h0d);
    burst(CMD_RD, 3'h3, 1'b1, 1'b0, 1'b1);
    burst(CMD_WR, 3'h1, 1'b1, 1'b0, 1'b1);
    @(posedge clk);
    pd(1'b0);
    mrs(18'h00050, 18'h00250, 5'h09);
    burst(CMD_RD, 3'h5, 1'b0, 1'b0, 1'b0);
    results();
  end

endmodule : sdram_base_mode_register_decode_bench

`default_nettype wire
